// file: hdl/cpl_regs.vh
/*
 * Register map, field positions, reset values and mode codes of the
 * color palette lookup block.
 * Assumes a 32-bit classic Wishbone slave; each register takes one
 * word, byte address = register index * 4.
 */
`ifndef CPL_REGS_VH
`define CPL_REGS_VH

// register indices; byte address is index times four
`define CPL_IDX_ENTRY_PTR 6'h15
`define CPL_IDX_BANK_CHOICE 6'h16
`define CPL_IDX_DATA_PORT 6'h17
`define CPL_IDX_DISP_CFG 6'h18

// entry pointer register fields
`define CPL_PTR_LSB 0
`define CPL_PTR_MSB 3
`define CPL_SEL_LSB 4
`define CPL_SEL_MSB 5

// bank choice register fields
`define CPL_BANK_BLUE_LSB 0
`define CPL_BANK_GREEN_LSB 2
`define CPL_BANK_RED_LSB 4

// display configuration register fields
`define CPL_CFG_DEPTH_LSB 0
`define CPL_CFG_DEPTH_MSB 1
`define CPL_CFG_MONO_BIT 2

// color element select codes
`define CPL_SEL_AUTO 2'h0
`define CPL_SEL_RED 2'h1
`define CPL_SEL_GREEN 2'h2
`define CPL_SEL_BLUE 2'h3

// element selector states
`define CPL_ELEM_RED 2'h0
`define CPL_ELEM_GREEN 2'h1
`define CPL_ELEM_BLUE 2'h2

// color depth codes
`define CPL_DEPTH_1BPP 2'h0
`define CPL_DEPTH_2BPP 2'h1
`define CPL_DEPTH_4BPP 2'h2
`define CPL_DEPTH_8BPP 2'h3

// reset values
`define CPL_RST_PTR 4'h0
`define CPL_RST_BANK 6'h00
`define CPL_RST_CFG 3'h0
`define CPL_RST_ELEM 4'h0

`define CPL_ENTRIES 16

`endif

// file: hdl/cpl_palette.v
/*
 * Sixteen-entry red/green/blue palette with its host registers on a
 * classic Wishbone slave, and the display path that serialises packed
 * display bytes into pixels and looks each pixel up in the palette.
 * Assumes one clock for bus and display, a synchronous active-low
 * reset, and that the display byte source sits on the same clock.
 */
// Our own choice: the Wishbone interface to the registers.
// Operation
// - sixteen entries, four-bit red green blue
// - pointer write resets selector to red
// - pointer advances after one to three accesses
// - every data port access steps selector, or only pointer in single mode
// - data port carries one element, low nibble
// - bank choice holds three two-bit fields
// - one bpp uses bank times two plus bit
// - two bpp uses bank times four plus value
// - four bpp indexes directly, banks ignored
// - four bpp upper nibble shown first
// - eight bpp splits byte three three two
// - eight bpp red green two banks, blue four
// - auto mode visits red green blue, else single
// - monochrome write copied to all three elements
// - leftmost pixel sits in highest bits
// - eight bpp red 7:5 green 4:2 blue 1:0
`timescale 1ns/1ps
`include "cpl_regs.vh"

module cpl_palette (
    input wire ref_clk_in,
    input wire rst_n_in,
    input wire wb_cyc_in,
    input wire wb_stb_in,
    input wire wb_we_in,
    input wire [7:0] wb_adr_in,
    input wire [3:0] wb_sel_in,
    input wire [31:0] wb_dat_in,
    output reg [31:0] wb_dat_out,
    output reg wb_ack_out,
    input wire [7:0] disp_byte_in,
    input wire disp_byte_valid_in,
    output reg disp_byte_ready_out,
    output reg [3:0] pix_red_out,
    output reg [3:0] pix_green_out,
    output reg [3:0] pix_blue_out,
    output reg pix_valid_out
);

    reg [3:0] pal_red [0:15];
    reg [3:0] pal_green [0:15];
    reg [3:0] pal_blue [0:15];

    reg [3:0] entry_ptr;
    reg [1:0] elem_select;
    reg [1:0] elem_cur;
    reg [5:0] bank_choice;
    reg [2:0] disp_cfg;

    reg [7:0] shift_byte;
    reg [3:0] pix_left;
    reg [1:0] shift_depth;

    wire bus_req;
    wire [5:0] reg_idx;
    wire wr_lane0;
    wire [1:0] depth;
    wire mono;
    wire [1:0] elem_target;
    wire elem_last;

    reg [3:0] next_entry_ptr;
    reg [1:0] next_elem_cur;
    reg [31:0] next_rd_data;
    reg [3:0] elem_value;
    reg [3:0] pix_value;
    reg [3:0] addr_red;
    reg [3:0] addr_green;
    reg [3:0] addr_blue;
    reg [3:0] per_byte;

    integer i;

    // request taken on the first cycle only; ack blocks a repeat
    assign bus_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
    assign reg_idx = wb_adr_in[7:2];
    assign wr_lane0 = wb_we_in & wb_sel_in[0];
    assign depth = disp_cfg[`CPL_CFG_DEPTH_MSB:`CPL_CFG_DEPTH_LSB];
    assign mono = disp_cfg[`CPL_CFG_MONO_BIT];

    // auto mode walks elements, otherwise one fixed element
    assign elem_target = (elem_select == `CPL_SEL_AUTO) ? elem_cur :
        (elem_select - 2'h1);
    assign elem_last = (elem_select != `CPL_SEL_AUTO) ||
        (elem_cur == `CPL_ELEM_BLUE);

    // palette address of one color for a right-aligned pixel value
    function [3:0] cpl_addr;
        input [1:0] dep;
        input [1:0] bank;
        input [7:0] pix;
        input [1:0] color;
        begin
            case (dep)
                // banks of two in the low eight entries
                `CPL_DEPTH_1BPP: cpl_addr = {1'b0, bank, pix[0]};
                `CPL_DEPTH_2BPP: cpl_addr = {bank, pix[1:0]};
                // pixel is the address, banks ignored
                `CPL_DEPTH_4BPP: cpl_addr = pix[3:0];
                default: begin
                    // three, three and two bit indices
                    case (color)
                        // red index in the top bits
                        // bank low bit picks eight-entry half
                        `CPL_ELEM_RED: cpl_addr = {bank[0], pix[7:5]};
                        `CPL_ELEM_GREEN: cpl_addr = {bank[0], pix[4:2]};
                        // blue picks one of four banks
                        default: cpl_addr = {bank, pix[1:0]};
                    endcase
                end
            endcase
        end
    endfunction

    // pixels carried by one display byte
    function [3:0] cpl_per_byte;
        input [1:0] dep;
        begin
            case (dep)
                `CPL_DEPTH_1BPP: cpl_per_byte = 4'h8;
                `CPL_DEPTH_2BPP: cpl_per_byte = 4'h4;
                `CPL_DEPTH_4BPP: cpl_per_byte = 4'h2;
                default: cpl_per_byte = 4'h1;
            endcase
        end
    endfunction

    always @* begin
        case (elem_target)
            `CPL_ELEM_RED: elem_value = pal_red[entry_ptr];
            `CPL_ELEM_GREEN: elem_value = pal_green[entry_ptr];
            default: elem_value = pal_blue[entry_ptr];
        endcase
    end

    // selector and pointer after one data port access
    always @* begin
        next_entry_ptr = entry_ptr;
        next_elem_cur = elem_cur;
        if (elem_last) begin
            // advance once the element sequence completes
            next_entry_ptr = entry_ptr + 4'h1;
            next_elem_cur = `CPL_ELEM_RED;
        end else begin
            next_elem_cur = elem_cur + 2'h1;
        end
    end

    always @* begin
        next_rd_data = 32'h0000_0000;
        case (reg_idx)
            `CPL_IDX_ENTRY_PTR:
                next_rd_data = {26'h0, elem_select, entry_ptr};
            `CPL_IDX_BANK_CHOICE:
                next_rd_data = {26'h0, bank_choice};
            // element in the low nibble only
            `CPL_IDX_DATA_PORT:
                next_rd_data = {28'h0, elem_value};
            `CPL_IDX_DISP_CFG:
                next_rd_data = {29'h0, disp_cfg};
            default: next_rd_data = 32'h0000_0000;
        endcase
    end

    // bus slave: one ack per request, unmapped reads give zero
    always @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= 32'h0000_0000;
            entry_ptr <= `CPL_RST_PTR;
            elem_select <= `CPL_SEL_AUTO;
            elem_cur <= `CPL_ELEM_RED;
            bank_choice <= `CPL_RST_BANK;
            disp_cfg <= `CPL_RST_CFG;
            for (i = 0; i < `CPL_ENTRIES; i = i + 1) begin
                pal_red[i] <= `CPL_RST_ELEM;
                pal_green[i] <= `CPL_RST_ELEM;
                pal_blue[i] <= `CPL_RST_ELEM;
            end
        end else begin
            wb_ack_out <= bus_req;
            if (bus_req) begin
                wb_dat_out <= wb_we_in ? 32'h0000_0000 : next_rd_data;
                case (reg_idx)
                    `CPL_IDX_ENTRY_PTR: begin
                        if (wr_lane0) begin
                            entry_ptr <= wb_dat_in[3:0];
                            elem_select <= wb_dat_in[5:4];
                            elem_cur <= `CPL_ELEM_RED;
                        end
                    end
                    `CPL_IDX_BANK_CHOICE: begin
                        // red 5:4, green 3:2, blue 1:0
                        if (wr_lane0)
                            bank_choice <= wb_dat_in[5:0];
                    end
                    `CPL_IDX_DATA_PORT: begin
                        // a masked-off write still counts as an access
                        if (wr_lane0) begin
                            if (mono) begin
                                pal_red[entry_ptr] <= wb_dat_in[3:0];
                                pal_green[entry_ptr] <= wb_dat_in[3:0];
                                pal_blue[entry_ptr] <= wb_dat_in[3:0];
                            end else begin
                                case (elem_target)
                                    `CPL_ELEM_RED:
                                        pal_red[entry_ptr] <= wb_dat_in[3:0];
                                    `CPL_ELEM_GREEN:
                                        pal_green[entry_ptr] <=
                                            wb_dat_in[3:0];
                                    default:
                                        pal_blue[entry_ptr] <=
                                            wb_dat_in[3:0];
                                endcase
                            end
                        end
                        entry_ptr <= next_entry_ptr;
                        elem_cur <= next_elem_cur;
                    end
                    `CPL_IDX_DISP_CFG: begin
                        if (wr_lane0)
                            disp_cfg <= wb_dat_in[2:0];
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // current pixel value, taken from the top of the shifter
    always @* begin
        per_byte = cpl_per_byte(depth);
        case (shift_depth)
            `CPL_DEPTH_1BPP: pix_value = {3'h0, shift_byte[7]};
            `CPL_DEPTH_2BPP: pix_value = {2'h0, shift_byte[7:6]};
            default: pix_value = shift_byte[7:4];
        endcase
        addr_red = cpl_addr(shift_depth, bank_choice[5:4],
            shift_depth == `CPL_DEPTH_8BPP ? shift_byte :
            {4'h0, pix_value}, `CPL_ELEM_RED);
        addr_green = cpl_addr(shift_depth, bank_choice[3:2],
            shift_depth == `CPL_DEPTH_8BPP ? shift_byte :
            {4'h0, pix_value}, `CPL_ELEM_GREEN);
        addr_blue = cpl_addr(shift_depth, bank_choice[1:0],
            shift_depth == `CPL_DEPTH_8BPP ? shift_byte :
            {4'h0, pix_value}, `CPL_ELEM_BLUE);
    end

    // display path: one pixel per clock, a byte taken when idle
    always @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            shift_byte <= 8'h00;
            pix_left <= 4'h0;
            shift_depth <= `CPL_DEPTH_1BPP;
            disp_byte_ready_out <= 1'b1;
            pix_valid_out <= 1'b0;
            pix_red_out <= 4'h0;
            pix_green_out <= 4'h0;
            pix_blue_out <= 4'h0;
        end else begin
            pix_valid_out <= 1'b0;
            if (pix_left != 4'h0) begin
                pix_valid_out <= 1'b1;
                if (mono) begin
                    // gray panels take only the green element
                    pix_red_out <= pal_green[addr_green];
                    pix_green_out <= pal_green[addr_green];
                    pix_blue_out <= pal_green[addr_green];
                end else begin
                    pix_red_out <= pal_red[addr_red];
                    pix_green_out <= pal_green[addr_green];
                    pix_blue_out <= pal_blue[addr_blue];
                end
                // leftmost pixel first, shift toward msb
                case (shift_depth)
                    `CPL_DEPTH_1BPP: shift_byte <= {shift_byte[6:0], 1'b0};
                    `CPL_DEPTH_2BPP: shift_byte <= {shift_byte[5:0], 2'h0};
                    default: shift_byte <= {shift_byte[3:0], 4'h0};
                endcase
                pix_left <= pix_left - 4'h1;
                disp_byte_ready_out <= (pix_left == 4'h1);
            end else if (disp_byte_valid_in && disp_byte_ready_out) begin
                // depth is latched per byte so a change mid-byte is safe
                shift_byte <= disp_byte_in;
                shift_depth <= depth;
                pix_left <= per_byte;
                disp_byte_ready_out <= 1'b0;
            end
        end
    end

endmodule

// file: verification/cpl_palette_asserts.sv
/* port assertions for cpl_palette, bound to every instance.
   assumes one clock and the synchronous active-low reset. */
`timescale 1ns/1ps
module cpl_chk (
    input wire ref_clk_in,
    input wire rst_n_in,
    input wire wb_cyc_in,
    input wire wb_stb_in,
    input wire wb_we_in,
    input wire [7:0] wb_adr_in,
    input wire [3:0] wb_sel_in,
    input wire [31:0] wb_dat_in,
    input wire [31:0] wb_dat_out,
    input wire wb_ack_out,
    input wire [7:0] disp_byte_in,
    input wire disp_byte_valid_in,
    input wire disp_byte_ready_out,
    input wire [3:0] pix_red_out,
    input wire [3:0] pix_green_out,
    input wire [3:0] pix_blue_out,
    input wire pix_valid_out
);
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rst_n_in);
    wire req = wb_cyc_in && wb_stb_in;
    wire rd_ack = wb_ack_out && !wb_we_in;
    wire take = disp_byte_valid_in && disp_byte_ready_out;
    a_ack_follows: assert property (req && !wb_ack_out |=> wb_ack_out)
        else $error("no ack one cycle after request");
    a_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("ack held beyond one cycle");
    a_data_nibble: assert property (
        rd_ack && wb_adr_in == 8'h5C |-> wb_dat_out[31:4] == 28'h0)
        else $error("data port read wider than one element");
    a_bank_width: assert property (
        rd_ack && wb_adr_in == 8'h58 |-> wb_dat_out[31:8] == 24'h0)
        else $error("bank choice read has upper bits");
    a_unmapped_zero: assert property (rd_ack &&
        (wb_adr_in < 8'h54 || wb_adr_in > 8'h63) |-> wb_dat_out == 32'h0)
        else $error("unmapped read not zero");
    a_write_quiet: assert property (wb_ack_out && wb_we_in |->
        wb_dat_out == 32'h0)
        else $error("read data not zero on write");
    a_pix_latency: assert property (take |=> !disp_byte_ready_out ##1
        pix_valid_out)
        else $error("first pixel not two cycles after byte");
    a_burst_bound: assert property (take |=> !disp_byte_ready_out ##[1:8]
        disp_byte_ready_out)
        else $error("byte takes more than eight pixels");
    a_ready_last: assert property ($rose(disp_byte_ready_out) |->
        pix_valid_out)
        else $error("ready rose without last pixel");
    a_pix_stream: assert property (pix_valid_out && !disp_byte_ready_out
        |=> pix_valid_out)
        else $error("gap inside a pixel burst");
endmodule
bind cpl_palette cpl_chk cpl_chk_i (.ref_clk_in, .rst_n_in, .wb_cyc_in,
    .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out,
    .wb_ack_out, .disp_byte_in, .disp_byte_valid_in, .disp_byte_ready_out,
    .pix_red_out, .pix_green_out, .pix_blue_out, .pix_valid_out);

// file: verification/cpl_palette_tb.sv
/* self-checking bench for cpl_palette: register traffic and pixels.
   assumes cpl_palette and its checker are compiled beside it. */
`timescale 1ns/1ps
module color_palette_lookup_tb_top;
    reg clk = 1'b0;
    reg rst_n = 1'b0;
    reg cs = 1'b0;
    reg we = 1'b0;
    reg [7:0] adr = 8'h00;
    reg [31:0] wdat = 32'h0;
    reg [7:0] db = 8'h00;
    reg dv = 1'b0;
    reg [3:0] wsel = 4'hF;
    // msk drops lane 0 so a data port write stores nothing
    reg msk = 1'b0;
    wire [31:0] rdat;
    wire ack, drdy, pv;
    wire [3:0] pr, pg, pb;
    integer fails = 0;
    integer cmp_count = 0;
    integer cyc_n = 0;
    integer i, s, k;
    // lfsr starts at 77
    reg [7:0] seed = 8'h4D;
    reg [31:0] rd;
    reg [3:0] mr [0:15];
    reg [3:0] mg [0:15];
    reg [3:0] mb [0:15];
    reg [3:0] ptr = 4'h0;
    reg [1:0] sel = 2'h0;
    reg [1:0] elem = 2'h0;
    reg mono = 1'b0;
    reg [1:0] d;
    reg [7:0] bank, cur;
    always #50 clk = ~clk;
    cpl_palette cpl_palette_i (.ref_clk_in(clk), .rst_n_in(rst_n),
        .wb_cyc_in(cs), .wb_stb_in(cs), .wb_we_in(we), .wb_adr_in(adr),
        .wb_sel_in(wsel), .wb_dat_in(wdat), .wb_dat_out(rdat),
        .wb_ack_out(ack), .disp_byte_in(db), .disp_byte_valid_in(dv),
        .disp_byte_ready_out(drdy), .pix_red_out(pr), .pix_green_out(pg),
        .pix_blue_out(pb), .pix_valid_out(pv));
    function [7:0] lfsr(input [7:0] x);
        lfsr = {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction
    function [3:0] pidx(input [2:0] k, input [1:0] c);
        reg [1:0] f;
        begin
            f = 2'(bank >> (4 - 2 * c));
            case (d)
            2'h0: pidx = {1'b0, f, cur[7 - k]};
            2'h1: pidx = {f, cur[7 - 2 * k -: 2]};
            2'h2: pidx = k[0] ? cur[3:0] : cur[7:4];
            default: pidx = (c == 2'h2) ? {f, cur[1:0]} :
                c[0] ? {f[0], cur[4:2]} : {f[0], cur[7:5]};
            endcase
        end
    endfunction
    task end_sim;
        begin
            $display("checks %0d mismatches %0d", cmp_count, fails);
            if (fails == 0 && cmp_count > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    task chk(input [63:0] what, input [31:0] seen, input [31:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== exp) begin
                fails = fails + 1;
                $display("wrong value %0s exp %h seen %h", what, exp, seen);
            end
        end
    endtask
    task wb(input w, input [7:0] a, input [31:0] v);
        begin
            @(posedge clk);
            cs <= 1'b1;
            we <= w;
            adr <= a;
            wdat <= v;
            wsel <= msk ? 4'hE : 4'hF;
            @(posedge clk);
            while (ack !== 1'b1) @(posedge clk);
            rd = rdat;
            cs <= 1'b0;
        end
    endtask
    task setp(input [3:0] p, input [1:0] s2);
        begin
            wb(1'b1, 8'h54, {26'h0, s2, p});
            ptr = p;
            sel = s2;
            elem = 2'h0;
        end
    endtask
    task dp(input w);
        reg [1:0] e;
        reg [3:0] x;
        reg st;
        begin
            seed = lfsr(seed);
            st = w && !msk;
            e = sel ? sel - 2'h1 : elem;
            x = e == 2'h0 ? mr[ptr] : e == 2'h1 ? mg[ptr] : mb[ptr];
            // upper lanes carry garbage that must be dropped
            wb(w, 8'h5C, {4{seed}});
            if (!w)
                chk("data", rd, x);
            if (st && (mono || e == 2'h0))
                mr[ptr] = seed[3:0];
            if (st && (mono || e == 2'h1))
                mg[ptr] = seed[3:0];
            if (st && (mono || e == 2'h2))
                mb[ptr] = seed[3:0];
            if (sel == 2'h0 && elem != 2'h2)
                elem = elem + 2'h1;
            else begin
                elem = 2'h0;
                ptr = ptr + 4'h1;
            end
        end
    endtask
    task send;
        begin
            @(posedge clk);
            dv <= 1'b1;
            db <= cur;
            @(negedge clk);
            while (drdy !== 1'b1) @(negedge clk);
            @(posedge clk);
            dv <= 1'b0;
            db <= ~cur;
            for (k = 0; k < (8 >> d); k = k + 1) begin
                @(negedge clk);
                while (pv !== 1'b1) @(negedge clk);
                // gray panels show the green element on all three
                chk("red", pr, mono ? mg[pidx(k, 2'h1)] :
                    mr[pidx(k, 2'h0)]);
                chk("green", pg, mg[pidx(k, 2'h1)]);
                chk("blue", pb, mono ? mg[pidx(k, 2'h1)] :
                    mb[pidx(k, 2'h2)]);
            end
        end
    endtask
    always @(posedge clk) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 8000) begin
            fails = fails + 1;
            end_sim;
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        for (i = 0; i < 5; i = i + 1) begin
            wb(1'b0, i == 4 ? 8'h7C : 8'h54 + 8'(i * 4), 32'h0);
            chk("reset", rd, 32'h0);
        end
        $display("reset test done");
        setp(4'h0, 2'h0);
        for (i = 0; i < 48; i = i + 1)
            dp(1'b1);
        wb(1'b0, 8'h54, 32'h0);
        chk("pointer", rd, 32'h0);
        for (i = 0; i < 48; i = i + 1)
            dp(1'b0);
        $display("fill test done");
        setp(4'h5, 2'h0);
        dp(1'b0);
        dp(1'b0);
        setp(4'h5, 2'h0);
        dp(1'b0);
        for (s = 1; s < 4; s = s + 1) begin
            setp(4'hE, 2'(s));
            dp(1'b1);
            dp(1'b1);
            wb(1'b0, 8'h54, 32'h0);
            chk("pointer", rd, {26'h0, 2'(s), 4'h0});
            setp(4'hE, 2'(s));
            dp(1'b0);
            dp(1'b0);
        end
        $display("single color test done");
        wb(1'b1, 8'h60, 32'h4);
        mono = 1'b1;
        setp(4'h3, 2'h1);
        dp(1'b1);
        wb(1'b1, 8'h60, 32'h0);
        mono = 1'b0;
        setp(4'h3, 2'h0);
        for (i = 0; i < 3; i = i + 1)
            dp(1'b0);
        $display("mono test done");
        setp(4'h7, 2'h0);
        msk = 1'b1;
        for (i = 0; i < 3; i = i + 1)
            dp(1'b1);
        msk = 1'b0;
        wb(1'b0, 8'h54, 32'h0);
        chk("pointer", rd, 32'h8);
        setp(4'h7, 2'h0);
        for (i = 0; i < 3; i = i + 1)
            dp(1'b0);
        $display("lane mask test done");
        for (i = 0; i < 16; i = i + 1) begin
            d = 2'(i / 4);
            seed = lfsr(seed);
            bank = seed & 8'h3F;
            cur = lfsr(seed) ^ 8'(i);
            mono = i[1];
            wb(1'b1, 8'h60, {29'h0, mono, d});
            wb(1'b0, 8'h60, 32'h0);
            chk("config", rd, {29'h0, mono, d});
            wb(1'b1, 8'h58, {24'h0, bank});
            wb(1'b0, 8'h58, 32'h0);
            chk("bank", rd, {24'h0, bank});
            send;
        end
        mono = 1'b0;
        $display("pixel test done");
        end_sim;
    end
endmodule
